// >>> test/pin_status_override_regs_bench.sv
module pin_status_override_regs_bench
  import pin_status_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct packed {
    logic [2:0] usb;
    logic [2:0] chg;
    logic [3:0] main;
    logic [15:0] exp;
  } row_s;

  logic clock;
  logic reset;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic wr;
  logic rd;
  logic [DATA_W-1:0] rdata;
  logic [PIN_N-1:0] pin_in;
  logic [PIN_N-1:0] pin_out;
  logic [PIN_N-1:0] pin_oe;
  logic [PIN_N-1:0] pin_is_output;
  logic [COMP_N-1:0] comp_raw;
  logic comparator_force_enable;
  logic [COMP_N-1:0] debounce_in;
  logic [2:0] usb_power_state;
  logic [2:0] charger_state;
  logic [3:0] main_power_state;
  logic irq;
  int err_total = 0;
  int n_tests = 0;

  // Every listed state code of the three machines appears at least once
  row_s rows [7] = '{
    '{3'h1, 3'h0, 4'h2, 16'h0102},
    '{3'h5, 3'h1, 4'hD, 16'h051D},
    '{3'h4, 3'h2, 4'hC, 16'h042C},
    '{3'h2, 3'h3, 4'hF, 16'h023F},
    '{3'h6, 3'h4, 4'h2, 16'h0642},
    '{3'h1, 3'h6, 4'hD, 16'h016D},
    '{3'h5, 3'h5, 4'hF, 16'h055F}
  };

  pin_status_override_regs DUT (
    .clock(clock), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe(pin_oe), .pin_is_output(pin_is_output), .comp_raw(comp_raw),
    .comparator_force_enable(comparator_force_enable),
    .debounce_in(debounce_in), .usb_power_state(usb_power_state),
    .charger_state(charger_state), .main_power_state(main_power_state),
    .irq(irq)
  );

  // ----------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------
  task automatic conclude();
    if (err_total == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : conclude

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic idle(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : idle

  // Strobes are raised after an edge and dropped after the taking edge
  task automatic wr_reg(input logic [7:0] idx, input logic [15:0] d);
    @(posedge clock);
    wr <= 1'h1;
    addr <= {idx, 2'h0};
    wdata <= d;
    @(posedge clock);
    wr <= 1'h0;
    #1;
  endtask : wr_reg

  // Read data stand only in the cycle after the strobe
  task automatic rd_chk(input logic [7:0] idx, input logic [15:0] exp);
    @(posedge clock);
    rd <= 1'h1;
    addr <= {idx, 2'h0};
    @(posedge clock);
    rd <= 1'h0;
    #1;
    chk(rdata, exp);
  endtask : rd_chk

  // ----------------------------------------------------------------------
  // Clock and watchdog
  // ----------------------------------------------------------------------
  initial begin
    clock = 1'h0;
    forever #5 clock = ~clock;
  end

  // Whole run needs about 130 cycles; over twenty times that means a hang
  initial begin
    repeat (3000) @(posedge clock);
    err_total++;
    conclude();
  end

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    reset = 1'h1;
    addr = '0;
    wdata = '0;
    wr = 1'h0;
    rd = 1'h0;
    pin_in = '0;
    pin_is_output = '0;
    comp_raw = '0;
    comparator_force_enable = 1'h0;
    usb_power_state = '0;
    charger_state = '0;
    main_power_state = '0;
    idle(20);
    reset <= 1'h0;
    idle(1);
    chk(pin_out, 16'h0000);
    chk(irq, 16'h0000);
    rd_chk(PIN_LEVEL_STATUS_IDX, 16'hE000);
    rd_chk(STATE_MACHINE_STATUS_IDX, 16'h0000);
    for (int i = 0; i < 7; i++) begin
      usb_power_state <= rows[i].usb;
      charger_state <= rows[i].chg;
      main_power_state <= rows[i].main;
      rd_chk(STATE_MACHINE_STATUS_IDX, rows[i].exp);
    end
    // Read-only status ignores writes; unmapped and clear read zero
    wr_reg(STATE_MACHINE_STATUS_IDX, 16'hFFFF);
    rd_chk(STATE_MACHINE_STATUS_IDX, 16'h055F);
    rd_chk(8'h10, 16'h0000);
    rd_chk(EVENT_CLEAR_IDX, 16'h0000);
    // Input pins: level readback, edge flags, clear by zero write
    wr_reg(EVENT_ENABLE_IDX, 16'h007F);
    rd_chk(EVENT_ENABLE_IDX, 16'h007F);
    pin_in <= 6'h2A;
    idle(6);
    rd_chk(PIN_LEVEL_STATUS_IDX, 16'hE02A);
    rd_chk(EVENT_STATUS_IDX, 16'h002A);
    chk(irq, 16'h0001);
    wr_reg(PIN_LEVEL_STATUS_IDX, 16'h0000);
    rd_chk(EVENT_STATUS_IDX, 16'h0000);
    chk(pin_out, 16'h0000);
    pin_in <= 6'h00;
    idle(6);
    rd_chk(PIN_LEVEL_STATUS_IDX, 16'hE000);
    // A one written to an input pin leaves its flag alone
    wr_reg(PIN_LEVEL_STATUS_IDX, 16'h0008);
    rd_chk(EVENT_STATUS_IDX, 16'h0008);
    chk(irq, 16'h0001);
    wr_reg(EVENT_ENABLE_IDX, 16'h0000);
    chk(irq, 16'h0000);
    wr_reg(EVENT_ENABLE_IDX, 16'h007F);
    wr_reg(EVENT_CLEAR_IDX, 16'h0008);
    rd_chk(EVENT_STATUS_IDX, 16'h0000);
    chk(irq, 16'h0000);
    // Edge on pin 0 lands in the very cycle of a zero write: set wins
    pin_in <= 6'h01;
    idle(1);
    wr_reg(PIN_LEVEL_STATUS_IDX, 16'h0000);
    rd_chk(EVENT_STATUS_IDX, 16'h0001);
    wr_reg(EVENT_CLEAR_IDX, 16'h0001);
    rd_chk(EVENT_STATUS_IDX, 16'h0000);
    // Output pins: written level drives the pin, flags untouched
    pin_is_output <= 6'h3F;
    idle(2);
    chk(pin_oe, 16'h003F);
    wr_reg(PIN_LEVEL_STATUS_IDX, 16'h0015);
    idle(1);
    chk(pin_out, 16'h0015);
    wr_reg(PIN_LEVEL_STATUS_IDX, 16'h002A);
    idle(1);
    chk(pin_out, 16'h002A);
    rd_chk(EVENT_STATUS_IDX, 16'h0000);
    // Reset in mid-run returns the driven levels to zero
    reset <= 1'h1;
    pin_is_output <= '0;
    idle(2);
    reset <= 1'h0;
    idle(1);
    chk(pin_out, 16'h0000);
    chk(pin_oe, 16'h0000);
    rd_chk(EVENT_ENABLE_IDX, 16'h0000);
    // Comparators: raw readback, then forcing into debounce
    comp_raw <= 7'h55;
    idle(5);
    rd_chk(COMPARATOR_OVERRIDE_IDX, 16'hA500);
    chk(debounce_in, 16'h0055);
    comparator_force_enable <= 1'h1;
    wr_reg(COMPARATOR_OVERRIDE_IDX, 16'h8000);
    idle(2);
    chk(debounce_in, 16'h0040);
    wr_reg(COMPARATOR_OVERRIDE_IDX, 16'h4A00);
    idle(2);
    chk(debounce_in, 16'h002A);
    rd_chk(COMPARATOR_OVERRIDE_IDX, 16'hA500);
    comparator_force_enable <= 1'h0;
    idle(3);
    chk(debounce_in, 16'h0055);
    conclude();
  end

endmodule : pin_status_override_regs_bench

// >>> verilog/event_flags.sv
module event_flags #(
  parameter int WIDTH = 7,
  parameter logic [WIDTH-1:0] ENABLE_RST = '0
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic [WIDTH-1:0] set_in,
  input wire logic [WIDTH-1:0] clear_in,
  input wire logic enable_we,
  input wire logic [WIDTH-1:0] enable_wdata,
  output logic [WIDTH-1:0] status_r,
  output logic [WIDTH-1:0] enable_r,
  output logic irq
);

  logic [WIDTH-1:0] status_nxt;

  // ----------------------------------------------------------------------
  // Sticky flags: a set in the clear cycle is kept
  // ----------------------------------------------------------------------
  assign status_nxt = (status_r & ~clear_in) | set_in;
  assign irq = |(status_r & enable_r);

  always_ff @(posedge clock) begin
    if (reset) begin
      status_r <= '0;
      enable_r <= ENABLE_RST;
    end else begin
      status_r <= status_nxt;
      if (enable_we) begin
        enable_r <= enable_wdata;
      end
    end
  end

endmodule : event_flags

// >>> verilog/level_sync.sv
module level_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage_r;

  // ----------------------------------------------------------------------
  // Two flops per bit; the first is read only by the second
  // ----------------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (reset) begin
      stage_r <= '0;
      sync_out <= '0;
    end else begin
      stage_r <= async_in;
      sync_out <= stage_r;
    end
  end

endmodule : level_sync

// >>> verilog/pin_status_override_regs.sv
// Behaviour
// - An input pin's level bit reads the synchronised level of that pin.
// - Writing zero to an input pin's level bit clears its event flag.
// - Writing an output pin's level bit stores it and drives the pin.
// - All six pin level bits are zero after reset.
// - The comparator register reads the raw comparator outputs.
// - With forcing enabled the forced bits feed debounce, else the raw.
// - Status bits 10:8 show the USB power state, zero after reset.
// - Status bits 6:4 show the charger state, zero after reset.
// - Status bits 3:0 show the main power state, zero after reset.
module pin_status_override_regs
  import pin_status_pkg::*;
#(
  parameter int PINS = pin_status_pkg::PIN_N
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic [pin_status_pkg::ADDR_W-1:0] addr,
  input wire logic [pin_status_pkg::DATA_W-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [pin_status_pkg::DATA_W-1:0] rdata,
  input wire logic [PINS-1:0] pin_in,
  output logic [PINS-1:0] pin_out,
  output logic [PINS-1:0] pin_oe,
  input wire logic [PINS-1:0] pin_is_output,
  input wire logic [pin_status_pkg::COMP_N-1:0] comp_raw,
  input wire logic comparator_force_enable,
  output logic [pin_status_pkg::COMP_N-1:0] debounce_in,
  input wire logic [2:0] usb_power_state,
  input wire logic [2:0] charger_state,
  input wire logic [3:0] main_power_state,
  output logic irq
);

  import pin_status_pkg::*;

  // ----------------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------------
  wire hit_level = reg_hit(addr, PIN_LEVEL_STATUS_IDX);
  wire hit_comp = reg_hit(addr, COMPARATOR_OVERRIDE_IDX);
  wire hit_state = reg_hit(addr, STATE_MACHINE_STATUS_IDX);
  wire hit_evt = reg_hit(addr, EVENT_STATUS_IDX);
  wire hit_clr = reg_hit(addr, EVENT_CLEAR_IDX);
  wire hit_en = reg_hit(addr, EVENT_ENABLE_IDX);

  wire wr_level = wr && hit_level;
  wire wr_comp = wr && hit_comp;
  wire wr_clr = wr && hit_clr;
  wire wr_en = wr && hit_en;

  // ----------------------------------------------------------------------
  // Pin and comparator synchronisers
  // ----------------------------------------------------------------------
  logic [PINS-1:0] pin_sync;
  logic [PINS-1:0] pin_prev_r;
  logic [COMP_N-1:0] comp_sync;
  logic [COMP_N-1:0] comp_prev_r;

  level_sync #(.WIDTH(PINS)) u_pin_sync (
    .clock(clock),
    .reset(reset),
    .async_in(pin_in),
    .sync_out(pin_sync)
  );

  level_sync #(.WIDTH(COMP_N)) u_comp_sync (
    .clock(clock),
    .reset(reset),
    .async_in(comp_raw),
    .sync_out(comp_sync)
  );

  // ----------------------------------------------------------------------
  // Pin level register and drive
  // ----------------------------------------------------------------------
  logic [PINS-1:0] level_r;
  logic [PINS-1:0] level_nxt;
  logic [PINS-1:0] level_view;
  logic [PINS-1:0] pin_edge;
  logic [PINS-1:0] pin_clear;

  // Only output pins take the written value; an input keeps its old drive
  assign level_nxt = wr_level ?
    ((level_r & ~pin_is_output) | (wdata[PINS-1:0] & pin_is_output)) :
    level_r;
  assign level_view = (pin_sync & ~pin_is_output) |
                      (level_r & pin_is_output);
  // Edges are taken after the second flop, never from the first
  assign pin_edge = (pin_sync ^ pin_prev_r) & ~pin_is_output;
  assign pin_clear = wr_level ?
    (~wdata[PINS-1:0] & ~pin_is_output) : '0;

  always_ff @(posedge clock) begin
    if (reset) begin
      level_r <= PIN_LEVEL_RST;
      pin_prev_r <= '0;
      pin_out <= '0;
      pin_oe <= '0;
    end else begin
      level_r <= level_nxt;
      pin_prev_r <= pin_sync;
      pin_out <= level_nxt;
      pin_oe <= pin_is_output;
    end
  end

  // ----------------------------------------------------------------------
  // Comparator override
  // ----------------------------------------------------------------------
  logic [COMP_N-1:0] force_r;
  logic [COMP_N-1:0] debounce_nxt;
  logic comp_change;

  assign debounce_nxt = comparator_force_enable ?
                        force_r : comp_sync;
  assign comp_change = |(comp_sync ^ comp_prev_r);

  always_ff @(posedge clock) begin
    if (reset) begin
      force_r <= COMP_FORCE_RST;
      comp_prev_r <= '0;
      debounce_in <= '0;
    end else begin
      if (wr_comp) begin
        force_r <= {wdata[15:13], wdata[11:8]};
      end
      comp_prev_r <= comp_sync;
      debounce_in <= debounce_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Event flags and interrupt
  // ----------------------------------------------------------------------
  logic [EVT_N-1:0] evt_set;
  logic [EVT_N-1:0] evt_clear;
  logic [EVT_N-1:0] evt_status;
  logic [EVT_N-1:0] evt_enable;

  assign evt_set = {comp_change, pin_edge};
  // Either clear path may act; a fresh edge still wins
  assign evt_clear = (wr_clr ? wdata[EVT_N-1:0] : '0) |
                     {1'b0, pin_clear};

  event_flags #(
    .WIDTH(EVT_N),
    .ENABLE_RST(EVT_ENABLE_RST)
  ) u_flags (
    .clock(clock),
    .reset(reset),
    .set_in(evt_set),
    .clear_in(evt_clear),
    .enable_we(wr_en),
    .enable_wdata(wdata[EVT_N-1:0]),
    .status_r(evt_status),
    .enable_r(evt_enable),
    .irq(irq)
  );

  // ----------------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------------
  wire [DATA_W-1:0] level_word = {PIN_UNUSED_VAL, 7'h00, level_view};
  wire [DATA_W-1:0] comp_word =
    {comp_sync[6:4], 1'b0, comp_sync[3:0], 8'h00};
  wire [DATA_W-1:0] state_word =
    {5'h00, usb_power_state, 1'b0,
     charger_state, main_power_state};
  wire [DATA_W-1:0] evt_word = {9'h000, evt_status};
  wire [DATA_W-1:0] en_word = {9'h000, evt_enable};

  // Clear register is write-only; unmapped reads answer zero
  wire [DATA_W-1:0] read_nxt =
    hit_level ? level_word :
    hit_comp ? comp_word :
    hit_state ? state_word :
    hit_evt ? evt_word :
    hit_en ? en_word : READ_IDLE;

  always_ff @(posedge clock) begin
    if (reset) begin
      rdata <= READ_IDLE;
    end else begin
      rdata <= rd ? read_nxt : READ_IDLE;
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  wire rd_level = rd && hit_level;
  wire rd_comp = rd && hit_comp;
  wire rd_state = rd && hit_state;

  sequence level_read_s;
    rd_level && $stable(pin_is_output);
  endsequence

  sequence state_write_then_read_s;
    wr && hit_state ##1 rd_state;
  endsequence

  sequence force_held_s;
    comparator_force_enable && !wr_comp;
  endsequence

  property reset_level_p;
    @(posedge clock) disable iff (1'b0)
      reset |=> (level_r == '0 && pin_out == '0);
  endproperty

  level_reset_a: assert property (reset_level_p)
    else $error("pin level not zero after reset");

  pin_read_a: assert property (
    @(posedge clock) disable iff (reset)
      level_read_s |=> ((rdata[PINS-1:0] ^ $past(pin_sync)) &
                        ~$past(pin_is_output)) == '0)
    else $error("input pin level misread");

  flag_clear_a: assert property (
    @(posedge clock) disable iff (reset)
      wr_level |=> (evt_status[PINS-1:0] &
                    $past(pin_clear & ~pin_edge)) == '0)
    else $error("pin event flag not cleared by zero write");

  pin_drive_a: assert property (
    @(posedge clock) disable iff (reset)
      wr_level ##1 !wr_level |=> ((pin_out ^ $past(wdata[PINS-1:0], 2)) &
                                  $past(pin_is_output, 2) &
                                  $past(pin_is_output)) == '0)
    else $error("output pin not driven to written level");

  comp_read_a: assert property (
    @(posedge clock) disable iff (reset)
      rd_comp |=> rdata[15:13] == $past(comp_sync[6:4]) &&
                  rdata[11:8] == $past(comp_sync[3:0]) &&
                  rdata[12] == 1'b0)
    else $error("comparator readback wrong");

  force_sel_a: assert property (
    @(posedge clock) disable iff (reset)
      force_held_s ##1 force_held_s |=> debounce_in == $past(force_r))
    else $error("forced value not fed to debounce");

  raw_sel_a: assert property (
    @(posedge clock) disable iff (reset)
      !comparator_force_enable |=> debounce_in == $past(comp_sync))
    else $error("raw comparator not fed to debounce");

  usb_state_a: assert property (
    @(posedge clock) disable iff (reset)
      rd_state |=> rdata[10:8] == $past(usb_power_state))
    else $error("usb power state readback wrong");

  charger_state_a: assert property (
    @(posedge clock) disable iff (reset)
      rd_state |=> rdata[6:4] == $past(charger_state))
    else $error("charger state readback wrong");

  main_state_a: assert property (
    @(posedge clock) disable iff (reset)
      rd_state |=> rdata[3:0] == $past(main_power_state))
    else $error("main power state readback wrong");

  state_ro_a: assert property (
    @(posedge clock) disable iff (reset)
      state_write_then_read_s |=> rdata[15:11] == 5'h00 &&
                                  rdata[7] == 1'b0 &&
                                  rdata[3:0] == $past(main_power_state))
    else $error("state status register not read-only");

  set_wins_a: assert property (
    @(posedge clock) disable iff (reset)
      (pin_edge[0] && pin_clear[0]) |=> evt_status[0])
    else $error("pin event lost during clear");

  // ----------------------------------------------------------------------
  // Bus framing and side effects
  // ----------------------------------------------------------------------
  // Software may poll without a strobe; rdata must stay quiet then so a
  // stale word is never mistaken for a fresh read
  sequence no_read_s;
    !rd;
  endsequence

  sequence unmapped_read_s;
    rd && !(hit_level || hit_comp || hit_state || hit_evt || hit_en);
  endsequence

  sequence comp_write_s;
    wr_comp;
  endsequence

  read_idle_a: assert property (
    @(posedge clock) disable iff (reset)
      no_read_s |=> rdata == READ_IDLE)
    else $error("read data not idle without strobe");

  unmapped_zero_a: assert property (
    @(posedge clock) disable iff (reset)
      unmapped_read_s |=> rdata == READ_IDLE)
    else $error("unmapped read not zero");

  state_pad_a: assert property (
    @(posedge clock) disable iff (reset)
      rd_state |=> rdata[15:11] == 5'h00 && rdata[7] == 1'b0)
    else $error("unlisted state status bits not zero");

  level_pad_a: assert property (
    @(posedge clock) disable iff (reset)
      rd_level |=> rdata[15:13] == PIN_UNUSED_VAL &&
                   rdata[12:PINS] == '0)
    else $error("pin level upper bits wrong");

  // An input pin's stored drive must not follow a write, or turning it
  // into an output later would glitch the pin to the written value
  input_keep_a: assert property (
    @(posedge clock) disable iff (reset)
      wr_level |=> ((level_r ^ $past(level_r)) &
                    ~$past(pin_is_output)) == '0)
    else $error("input pin drive level changed by write");

  oe_follow_a: assert property (
    @(posedge clock) disable iff (reset)
      !reset |=> pin_oe == $past(pin_is_output))
    else $error("pin output enable not following direction");

  force_store_a: assert property (
    @(posedge clock) disable iff (reset)
      comp_write_s |=> force_r == {$past(wdata[15:13]),
                                   $past(wdata[11:8])})
    else $error("comparator force bits not stored");

  pin_set_a: assert property (
    @(posedge clock) disable iff (reset)
      |pin_edge |=> (evt_status[PINS-1:0] & $past(pin_edge)) ==
                    $past(pin_edge))
    else $error("pin edge did not set its flag");

  comp_set_a: assert property (
    @(posedge clock) disable iff (reset)
      comp_change |=> evt_status[EVT_COMP_BIT])
    else $error("comparator change did not set its flag");

endmodule : pin_status_override_regs

// >>> verilog/pin_status_pkg.sv
package pin_status_pkg;

  // ----------------------------------------------------------------------
  // Bus geometry
  // ----------------------------------------------------------------------
  localparam int DATA_W = 16;
  localparam int ADDR_W = 10;
  localparam int IDX_W = 8;
  localparam int PIN_N = 6;
  localparam int COMP_N = 7;
  localparam int EVT_N = 7;

  // ----------------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------------
  localparam logic [IDX_W-1:0] PIN_LEVEL_STATUS_IDX = 8'hE6;
  localparam logic [IDX_W-1:0] COMPARATOR_OVERRIDE_IDX = 8'hE7;
  localparam logic [IDX_W-1:0] STATE_MACHINE_STATUS_IDX = 8'hE9;
  localparam logic [IDX_W-1:0] EVENT_STATUS_IDX = 8'hF0;
  localparam logic [IDX_W-1:0] EVENT_CLEAR_IDX = 8'hF1;
  localparam logic [IDX_W-1:0] EVENT_ENABLE_IDX = 8'hF2;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int PIN_LSB = 0;
  localparam int PIN_UNUSED_LSB = 13;
  localparam int COMP_SUPPLY_LSB = 13;
  localparam int COMP_CODEC_LSB = 8;
  localparam int USB_STATE_LSB = 8;
  localparam int CHARGER_STATE_LSB = 4;
  localparam int MAIN_STATE_LSB = 0;
  localparam int EVT_COMP_BIT = 6;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [PIN_N-1:0] PIN_LEVEL_RST = 6'h00;
  localparam logic [2:0] PIN_UNUSED_VAL = 3'h7;
  localparam logic [COMP_N-1:0] COMP_FORCE_RST = 7'h00;
  localparam logic [EVT_N-1:0] EVT_ENABLE_RST = 7'h00;
  localparam logic [DATA_W-1:0] READ_IDLE = 16'h0000;

  function automatic logic reg_hit(input logic [ADDR_W-1:0] addr,
                                   input logic [IDX_W-1:0] idx);
    reg_hit = (addr == {idx, 2'b00});
  endfunction : reg_hit

endpackage : pin_status_pkg
